// *** core/idp_pkg.sv ***
// Package of constants and types for the inbound data poison control block
package idp_pkg;

    // Widths
    localparam int unsigned DATA_W = 64;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned REG_W = 32;
    localparam int unsigned BE_W = 4;

    // Configuration offsets
    localparam logic [ADDR_W-1:0] OFS_SYS_CTL = 8'he0;
    localparam logic [ADDR_W-1:0] OFS_HUB_CTL = 8'he4;
    localparam logic [ADDR_W-1:0] OFS_BUF_CTL = 8'he8;
    localparam logic [ADDR_W-1:0] OFS_MEM_CTL = 8'hec;

    // Field position of the poisoning enable and its byte lane
    localparam int unsigned EN_BIT = 18;
    localparam int unsigned EN_LANE = 2;

    // Reset values of whole registers
    localparam logic [REG_W-1:0] RST_SYS_CTL = 32'h0020_0000;
    localparam logic [REG_W-1:0] RST_HUB_CTL = 32'h0004_0000;
    localparam logic [REG_W-1:0] RST_BUF_CTL = 32'h0000_0000;
    localparam logic [REG_W-1:0] RST_MEM_CTL = 32'h0000_0000;

    // Mask of the functional bit
    localparam logic [REG_W-1:0] EN_MASK = 32'h0004_0000;

    // Memory controller ECC modes
    typedef enum logic [1:0] {
        ECC_NONE,
        ECC_72BIT,
        ECC_SDC_X4
    } idp_ecc_mode_type;

    // Inbound data word with its detected parity error
    typedef struct packed {
        logic valid;
        logic par_err;
        logic [DATA_W-1:0] data;
    } idp_in_type;

    // Forwarded data word with internal parity and poison marker
    typedef struct packed {
        logic valid;
        logic poison;
        logic par;
        logic [DATA_W-1:0] data;
    } idp_out_type;

    // Read value of a control register: reset image with live enable bit
    function automatic logic [REG_W-1:0] ctl_image(input logic [REG_W-1:0] rst_val, input logic en);
        ctl_image = (rst_val & ~EN_MASK) | (en ? EN_MASK : '0);
    endfunction

endpackage

// *** core/idp_poison_stage.sv ***
// One inbound path: tags parity-errored words as poisoned or regenerates parity
`timescale 1ns/1ps
`default_nettype none
module idp_poison_stage
    import idp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic poison_en_i,
    // Data
    input wire idp_in_type in_i,
    output idp_out_type out_o
);

    // Poison decision for this word
    wire logic mark_w;
    // Good parity of incoming data
    wire logic good_par_w;
    // Next output word
    idp_out_type nxt_out;
    // Output register
    idp_out_type out_ff;

    // Poison only when enabled and an error is seen
    // conditional poison tag
    assign mark_w = in_i.valid && in_i.par_err && poison_en_i;
    assign good_par_w = ^in_i.data;

    // Build forwarded word; disabled path gets fresh good parity
    always_comb begin
        nxt_out.valid = in_i.valid;
        nxt_out.data = in_i.data;
        nxt_out.poison = mark_w;
        nxt_out.par = mark_w ? ~good_par_w : good_par_w;
    end

    // Register the word; poisoned words are forwarded, never dropped
    // forward poisoned data
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign out_o = out_ff;

    AST_POISON_MARK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (in_i.valid && in_i.par_err && poison_en_i) |=> (out_o.valid && out_o.poison))
        else $error("errored word not poisoned while enabled");

    AST_NO_POISON_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (in_i.valid && !poison_en_i) |=> (!out_o.poison && (out_o.par == ^out_o.data)))
        else $error("disabled path poisoned or bad parity");

    AST_FORWARD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        in_i.valid |=> (out_o.valid && out_o.data == $past(in_i.data)))
        else $error("word not forwarded");

    AST_CLEAN_WORD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (in_i.valid && !in_i.par_err) |=> !out_o.poison)
        else $error("clean word poisoned");

endmodule
`default_nettype wire

// *** core/idp_poison_ctl.sv ***
// Top of inbound data poison control: config registers and three paths
`timescale 1ns/1ps
`default_nettype none
module idp_poison_ctl
    import idp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Configuration access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic [BE_W-1:0] cfg_be_i,
    input wire logic [REG_W-1:0] cfg_wdata_i,
    output logic [REG_W-1:0] cfg_rdata_o,
    // Memory controller mode
    input wire idp_ecc_mode_type ecc_mode_i,
    // System bus path
    input wire idp_in_type sys_in_i,
    output idp_out_type sys_out_o,
    // Hub link path
    input wire idp_in_type hub_link_in_i,
    output idp_out_type hub_link_out_o,
    // Posted write buffer path
    input wire idp_in_type buf_in_i,
    output idp_out_type buf_out_o
);

    // Enable bits
    logic sys_en_ff;
    logic hub_en_ff;
    logic buf_en_ff;
    // Read data register
    logic [REG_W-1:0] rdata_ff;
    logic [REG_W-1:0] nxt_rdata;

    // Address decode
    wire logic hit_sys_w;
    wire logic hit_hub_w;
    wire logic hit_buf_w;
    wire logic hit_mem_w;
    // Write strobe for the lane holding the enable bit
    wire logic lane_wr_w;
    // Value written to the enable
    wire logic wr_bit_w;
    // ECC mode allows buffer poisoning
    wire logic ecc_on_w;
    // Effective buffer enable
    wire logic buf_eff_w;

    assign hit_sys_w = (cfg_addr_i == OFS_SYS_CTL);
    assign hit_hub_w = (cfg_addr_i == OFS_HUB_CTL);
    assign hit_buf_w = (cfg_addr_i == OFS_BUF_CTL);
    assign hit_mem_w = (cfg_addr_i == OFS_MEM_CTL);
    assign lane_wr_w = cfg_wr_i && cfg_be_i[EN_LANE];
    assign wr_bit_w = cfg_wdata_i[EN_BIT];

    // Buffer poisoning needs both enable and an ECC mode
    // ECC mode gate
    assign ecc_on_w = (ecc_mode_i == ECC_72BIT) || (ecc_mode_i == ECC_SDC_X4);
    assign buf_eff_w = buf_en_ff && ecc_on_w;

    // System bus enable, cleared at reset
    // reset cleared
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sys_en_ff <= RST_SYS_CTL[EN_BIT];
        end else if (lane_wr_w && hit_sys_w) begin
            sys_en_ff <= wr_bit_w;
        end
    end

    // Hub link enable, set at reset
    // reset set
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hub_en_ff <= RST_HUB_CTL[EN_BIT];
        end else if (lane_wr_w && hit_hub_w) begin
            hub_en_ff <= wr_bit_w;
        end
    end

    // Write buffer enable, its own register
    // separate buffer enable
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            buf_en_ff <= RST_BUF_CTL[EN_BIT];
        end else if (lane_wr_w && hit_buf_w) begin
            buf_en_ff <= wr_bit_w;
        end
    end

    // Read mux: reserved bits show their reset image, writes never touch them
    // reserved read reset
    always_comb begin
        nxt_rdata = '0;
        if (hit_sys_w) begin
            nxt_rdata = ctl_image(RST_SYS_CTL, sys_en_ff);
        end else if (hit_hub_w) begin
            nxt_rdata = ctl_image(RST_HUB_CTL, hub_en_ff);
        end else if (hit_buf_w) begin
            nxt_rdata = ctl_image(RST_BUF_CTL, buf_en_ff);
        end else if (hit_mem_w) begin
            nxt_rdata = RST_MEM_CTL;
        end
    end

    // Capture read data on a read, hold otherwise
    // 32-bit register read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= '0;
        end else if (cfg_rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign cfg_rdata_o = rdata_ff;

    // System bus path
    idp_poison_stage u_sys (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .poison_en_i(sys_en_ff),
        .in_i(sys_in_i),
        .out_o(sys_out_o)
    );

    // Hub link path
    idp_poison_stage u_hub_link (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .poison_en_i(hub_en_ff),
        .in_i(hub_link_in_i),
        .out_o(hub_link_out_o)
    );

    // Posted write buffer path, gated by ECC mode
    idp_poison_stage u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .poison_en_i(buf_eff_w),
        .in_i(buf_in_i),
        .out_o(buf_out_o)
    );

    AST_SYS_RESET: assert property (@(posedge clk_i)
        $fell(sys_rst_i) |-> !sys_en_ff)
        else $error("system bus enable not cleared after reset");

    AST_HUB_RESET: assert property (@(posedge clk_i)
        $fell(sys_rst_i) |-> hub_en_ff)
        else $error("hub link enable not set after reset");

    AST_BUF_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (lane_wr_w && hit_buf_w) |=> (buf_en_ff == $past(cfg_wdata_i[EN_BIT])))
        else $error("buffer enable did not take write");

    AST_BUF_MODE_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (buf_in_i.valid && buf_in_i.par_err && ecc_mode_i == ECC_NONE) |=> !buf_out_o.poison)
        else $error("buffer poisoned outside ECC mode");

    AST_BUF_MODE_ON: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (buf_in_i.valid && buf_in_i.par_err && buf_en_ff && ecc_mode_i == ECC_SDC_X4) |=> buf_out_o.poison)
        else $error("buffer not poisoned in ECC mode");

    AST_RSVD_SYS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cfg_rd_i && hit_sys_w) |=> ((cfg_rdata_o & ~EN_MASK) == (RST_SYS_CTL & ~EN_MASK)))
        else $error("system bus reserved bits wrong");

    AST_RD_HUB: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cfg_rd_i && hit_hub_w) |=> (cfg_rdata_o == ctl_image(RST_HUB_CTL, $past(hub_en_ff))))
        else $error("hub link register read wrong");

    AST_SYS_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (lane_wr_w && hit_sys_w) |=> (sys_en_ff == $past(cfg_wdata_i[EN_BIT])))
        else $error("system bus enable did not take write");

    AST_HUB_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (lane_wr_w && hit_hub_w) |=> (hub_en_ff == $past(cfg_wdata_i[EN_BIT])))
        else $error("hub link enable did not take write");

    AST_LANE_GUARD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cfg_wr_i && !cfg_be_i[EN_LANE]) |=> $stable({sys_en_ff, hub_en_ff, buf_en_ff}))
        else $error("write without enable lane changed an enable");

    AST_UNMAPPED_WR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cfg_wr_i && !(hit_sys_w || hit_hub_w || hit_buf_w)) |=> $stable({sys_en_ff, hub_en_ff, buf_en_ff}))
        else $error("unmapped write changed an enable");

    AST_RD_SYS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cfg_rd_i && hit_sys_w) |=> (cfg_rdata_o == ctl_image(RST_SYS_CTL, $past(sys_en_ff))))
        else $error("system bus register read wrong");

    AST_RD_BUF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cfg_rd_i && hit_buf_w) |=> (cfg_rdata_o == ctl_image(RST_BUF_CTL, $past(buf_en_ff))))
        else $error("write buffer register read wrong");

    AST_RD_MEM: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cfg_rd_i && hit_mem_w) |=> (cfg_rdata_o == RST_MEM_CTL))
        else $error("memory control register read wrong");

    AST_RD_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !cfg_rd_i |=> $stable(cfg_rdata_o))
        else $error("read data changed without a read");

    AST_BUF_MODE_72: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (buf_in_i.valid && buf_in_i.par_err && buf_en_ff && ecc_mode_i == ECC_72BIT) |=> buf_out_o.poison)
        else $error("buffer not poisoned in wide ECC mode");

    AST_BUF_EN_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (buf_in_i.valid && !buf_en_ff) |=> (!buf_out_o.poison && (buf_out_o.par == ^buf_out_o.data)))
        else $error("disabled buffer path poisoned or bad parity");

    AST_SYS_POISON: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (sys_in_i.valid && sys_in_i.par_err && sys_en_ff) |=> sys_out_o.poison)
        else $error("system bus word not poisoned while enabled");

    AST_SYS_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (sys_in_i.valid && !sys_en_ff) |=> !sys_out_o.poison)
        else $error("system bus word poisoned while disabled");

    AST_HUB_POISON: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (hub_link_in_i.valid && hub_link_in_i.par_err && hub_en_ff) |=> hub_link_out_o.poison)
        else $error("hub link word not poisoned while enabled");

    AST_HUB_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (hub_link_in_i.valid && !hub_en_ff) |=> !hub_link_out_o.poison)
        else $error("hub link word poisoned while disabled");

endmodule
`default_nettype wire

// *** verification/idp_agent_model.sv ***
// Behavioural inbound agent presenting one data word a cycle to a poison path
`timescale 1ns/1ps
`default_nettype none
module idp_agent_model
    import idp_pkg::*;
(
    // Word request from the bench
    input wire logic valid_i,
    input wire logic err_i,
    input wire logic [DATA_W-1:0] data_i,
    // Word toward the hub
    output var idp_in_type word_o
);
    // Idle cycles show inverted data so a stale word never looks held
    always_comb begin
        word_o.valid = valid_i;
        word_o.par_err = valid_i & err_i;
        word_o.data = valid_i ? data_i : ~data_i;
    end
endmodule
`default_nettype wire

// *** verification/test_inbound_data_poison_control.sv ***
// Self-checking bench for the inbound data poison control block
`timescale 1ns/1ps
`default_nettype none
module test_inbound_data_poison_control;
    import idp_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cfg_wr_i = 1'b0;
    logic cfg_rd_i = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00;
    logic [3:0] cfg_be_i = 4'h0;
    logic [31:0] cfg_wdata_i = 32'h0;
    wire logic [31:0] cfg_rdata_o;
    idp_ecc_mode_type ecc_mode_i = ECC_NONE;
    logic [2:0] a_v = 3'h0;
    logic [2:0] a_e = 3'h0;
    logic [63:0] a_d [3] = '{64'h0, 64'h0, 64'h0};
    idp_in_type in_w [3];
    idp_out_type out_w [3];
    int mismatches = 0;
    int n_compared = 0;
    logic [31:0] rs = 32'h0184;
    // Model state: enables, expected words and read data
    logic [2:0] en, x_v, x_p, x_q;
    logic [63:0] x_d [3];
    logic [31:0] x_r;
    logic armed = 1'b0;
    logic rd_seen = 1'b0;

    always #10 clk_i = ~clk_i;

    // One agent per inbound path: system bus, hub link, write buffer
    for (genvar k = 0; k < 3; k++) begin : g_src
        idp_agent_model idp_agent_model_i (.valid_i(a_v[k]), .err_i(a_e[k]), .data_i(a_d[k]), .word_o(in_w[k]));
    end

    idp_poison_ctl idp_poison_ctl_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .ecc_mode_i(ecc_mode_i), .sys_in_i(in_w[0]), .sys_out_o(out_w[0]), .hub_link_in_i(in_w[1]),
        .hub_link_out_o(out_w[1]), .buf_in_i(in_w[2]), .buf_out_o(out_w[2]));

    function automatic logic [31:0] nxt(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        nxt = x ^ (x << 5);
    endfunction

    // Read image: reserved bits at reset value, bit 18 live
    // image
    function automatic logic [31:0] image(input logic [7:0] a);
        case (a)
            8'he0: image = 32'h0020_0000 | {13'h0, en[0], 18'h0};
            8'he4: image = {13'h0, en[1], 18'h0};
            8'he8: image = {13'h0, en[2], 18'h0};
            default: image = 32'h0;
        endcase
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Reference model: expected results of each edge
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en = 3'b010;
            armed = 1'b0;
            rd_seen = 1'b0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                x_v[k] = in_w[k].valid;
                x_d[k] = in_w[k].data;
                x_p[k] = in_w[k].valid & in_w[k].par_err & en[k]
                    & (k < 2 || ecc_mode_i == ECC_72BIT || ecc_mode_i == ECC_SDC_X4);
                x_q[k] = ^in_w[k].data ^ x_p[k];
            end
            if (cfg_rd_i) begin
                rd_seen = 1'b1;
                x_r = image(cfg_addr_i);
            end
            // Only lane 2 of a mapped register changes state
            if (cfg_wr_i && cfg_be_i[2]) begin
                case (cfg_addr_i)
                    8'he0: en[0] = cfg_wdata_i[18];
                    8'he4: en[1] = cfg_wdata_i[18];
                    8'he8: en[2] = cfg_wdata_i[18];
                    default: ;
                endcase
            end
            armed = 1'b1;
        end
    end

    // Two reset phases of random traffic, checked at every falling edge
    initial begin
        for (int ph = 0; ph < 2; ph++) begin
            sys_rst_i = 1'b1;
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            sys_rst_i = 1'b0;
            repeat (800) begin
                @(negedge clk_i);
                for (int k = 0; k < 3; k++) begin
                    if (armed) begin
                        check(out_w[k].valid, x_v[k]);
                    end
                    if (armed && x_v[k]) begin
                        check(out_w[k].data, x_d[k]);
                        check(out_w[k].poison, x_p[k]);
                        check(out_w[k].par, x_q[k]);
                    end
                end
                if (rd_seen) begin
                    check(cfg_rdata_o, x_r);
                end
                rs = nxt(rs);
                a_v = rs[2:0];
                a_e = rs[5:3];
                for (int k = 0; k < 3; k++) begin
                    rs = nxt(rs);
                    a_d[k] = {rs, ~rs ^ 32'h5a5a_0f0f};
                end
                rs = nxt(rs);
                ecc_mode_i = idp_ecc_mode_type'(rs[1:0]);
                cfg_wr_i = rs[2];
                cfg_rd_i = rs[3];
                cfg_be_i = rs[7:4];
                cfg_addr_i = 8'he0 + {3'h0, rs[10:8], 2'h0};
                cfg_wdata_i = nxt(rs);
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
